// file: move_instruction_execution.sv
// move_instruction_execution: executes the core's data-move instructions
// assumes decode presents one word with a valid strobe; register file answers reads
// combinationally in the cycle its read strobe is high, on the same clock
//
// Notes on behaviour
// RULE1: indirect load copies addressed register into accumulator, updates only zero flag
// RULE2: pointer mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// RULE3: relative form addresses pointer plus signed -32..31 offset, pointer unchanged
// RULE4: indirect data ports hold nothing; access goes to pointer's address instead
// RULE5: pointers are 16-bit and wrap around at both ends
// RULE6: bank load writes 5-bit literal into bank select, no flags touched
// RULE7: page load writes 7-bit literal into program counter high latch, no flags
// RULE8: literal load puts 8-bit literal into accumulator in one cycle, no flags
// RULE9: unused bits of the literal load encoding are ignored by decode
// RULE10: store copies accumulator to 7-bit file address in one cycle, no flags
// RULE11: direct file address is joined with bank select to form full address

`timescale 1ns/1ps

module move_instruction_execution
  import move_exec_pkg::*;
(
  input  wire logic [INSTR_WIDTH-1:0] i_instr,
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_instr_valid,
  input  wire logic [7:0]             i_mem_rdata,
  output mem_req_type                 o_mem_req,
  output logic                        o_ready,
  output logic      [7:0]             o_accumulator,
  output logic      [4:0]             o_bank_select_reg,
  output logic      [6:0]             o_program_counter_high_latch,
  output logic                        o_zero_flag,
  output logic                        o_zero_update,
  output logic      [15:0]            o_pointer0,
  output logic      [15:0]            o_pointer1
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_type   state_reg;
  state_type   state_next;
  mem_req_type req_reg;
  mem_req_type req_next;
  logic        ready_reg;
  logic        ready_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [4:0]  bank_reg;
  logic [4:0]  bank_next;
  logic [6:0]  page_reg;
  logic [6:0]  page_next;
  logic        zero_reg;
  logic        zero_next;
  logic        zero_upd_reg;
  logic        zero_upd_next;
  logic [15:0] ptr_reg  [2];
  logic [15:0] ptr_next [2];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [3:0]  opcode;
  logic        take;
  logic        is_relative;
  logic        sel_n;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] stepped_ptr;
  logic [6:0]  file_addr;

  // full data address of a direct access, redirected through a pointer
  // when the file address names an indirect data port
  function automatic logic [15:0] direct_address(
    input logic [4:0]  bank,
    input logic [6:0]  faddr,
    input logic [15:0] ptr0,
    input logic [15:0] ptr1
  );
    logic [15:0] result;
    result = {4'h0, bank, faddr};  // see RULE11
    if (faddr == INDIRECT_DATA_PORT0_ADDR) begin
      result = ptr0;  // see RULE4
    end else if (faddr == INDIRECT_DATA_PORT1_ADDR) begin
      result = ptr1;  // see RULE4
    end
    return result;
  endfunction

  assign opcode      = i_instr[OPCODE_MSB:OPCODE_LSB];
  assign take        = i_instr_valid && ready_reg;
  assign is_relative = (opcode == OP_INDIRECT_LOAD_RELATIVE);
  assign sel_n       = is_relative ? i_instr[REL_SELECT_BIT] : i_instr[IND_SELECT_BIT];
  assign sel_ptr     = sel_n ? ptr_reg[1] : ptr_reg[0];
  assign file_addr   = i_instr[6:0];

  pointer_step u_pointer_step (
    .i_pointer      (sel_ptr),
    .i_mode         (i_instr[1:0]),
    .i_relative     (is_relative),
    .i_offset       (i_instr[5:0]),
    .o_eff_addr     (eff_addr),
    .o_next_pointer (stepped_ptr)
  );

  // ----------------------------------------------------------------
  // execution next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    req_next      = req_reg;
    req_next.wr   = 1'b0;
    req_next.rd   = 1'b0;
    acc_next      = acc_reg;
    bank_next     = bank_reg;
    page_next     = page_reg;
    zero_next     = zero_reg;
    zero_upd_next = 1'b0;
    ptr_next[0]   = ptr_reg[0];
    ptr_next[1]   = ptr_reg[1];
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          case (opcode)
            OP_LOAD_ACCUMULATOR_LITERAL: begin
              // bits 9:8 never looked at
              acc_next = i_instr[7:0];  // see RULE8 see RULE9
            end
            OP_STORE_ACCUMULATOR_TO_FILE: begin
              req_next.addr  = direct_address(bank_reg, file_addr,
                                              ptr_reg[0], ptr_reg[1]);
              req_next.wr    = 1'b1;  // see RULE10
              req_next.wdata = acc_reg;
            end
            OP_LOAD_BANK_LITERAL: begin
              bank_next = i_instr[4:0];  // see RULE6
            end
            OP_LOAD_PAGE_LITERAL: begin
              page_next = i_instr[6:0];  // see RULE7
            end
            OP_INDIRECT_LOAD_ACCUMULATOR, OP_INDIRECT_LOAD_RELATIVE: begin
              req_next.addr   = eff_addr;  // see RULE2 see RULE3
              req_next.rd     = 1'b1;
              state_next      = ST_READ;
              ptr_next[sel_n] = stepped_ptr;  // see RULE2 see RULE5
            end
            default: begin
              // other opcodes belong to other execution units
            end
          endcase
        end
      end
      ST_READ: begin
        acc_next      = i_mem_rdata;  // see RULE1
        zero_next     = (i_mem_rdata == 8'h00);
        zero_upd_next = 1'b1;
        state_next    = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // second cycle of an indirect load holds off the next word
    ready_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg    <= ST_IDLE;
      req_reg      <= '0;
      ready_reg    <= 1'b0;
      acc_reg      <= ACCUMULATOR_RESET;
      bank_reg     <= BANK_RESET;
      page_reg     <= PAGE_RESET;
      zero_reg     <= 1'b0;
      zero_upd_reg <= 1'b0;
      ptr_reg[0]   <= POINTER_RESET;
      ptr_reg[1]   <= POINTER_RESET;
    end else begin
      state_reg    <= state_next;
      req_reg      <= req_next;
      ready_reg    <= ready_next;
      acc_reg      <= acc_next;
      bank_reg     <= bank_next;
      page_reg     <= page_next;
      zero_reg     <= zero_next;
      zero_upd_reg <= zero_upd_next;
      ptr_reg[0]   <= ptr_next[0];
      ptr_reg[1]   <= ptr_next[1];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_mem_req                    = req_reg;
  assign o_ready                      = ready_reg;
  assign o_accumulator                = acc_reg;
  assign o_bank_select_reg            = bank_reg;
  assign o_program_counter_high_latch = page_reg;
  assign o_zero_flag                  = zero_reg;
  assign o_zero_update                = zero_upd_reg;
  assign o_pointer0                   = ptr_reg[0];
  assign o_pointer1                   = ptr_reg[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_take_ind;
    take && (opcode == OP_INDIRECT_LOAD_ACCUMULATOR);
  endsequence

  sequence s_take_rel;
    take && is_relative;
  endsequence

  sequence s_take_store;
    take && (opcode == OP_STORE_ACCUMULATOR_TO_FILE);
  endsequence

  sequence s_read_done;
    o_mem_req.rd ##1 (o_zero_update && !o_mem_req.rd && o_ready);
  endsequence

  chk_zero_after_read: assert property ( // see RULE1
    s_take_ind |=> s_read_done ##0 (o_zero_flag == (o_accumulator == 8'h00)))
    else $error("indirect load did not finish with zero flag in two cycles");

  chk_mode_pre_inc: assert property ( // see RULE2
    s_take_ind ##0 (i_instr[1:0] == MODE_PRE_INC)
      |=> (o_mem_req.addr == 16'($past(sel_ptr) + POINTER_STEP))
          && (($past(sel_n) ? o_pointer1 : o_pointer0) == o_mem_req.addr))
    else $error("pre-increment address or pointer wrong");

  chk_mode_post_dec: assert property ( // see RULE2
    s_take_ind ##0 (i_instr[1:0] == MODE_POST_DEC)
      |=> (o_mem_req.addr == $past(sel_ptr))
          && (($past(sel_n) ? o_pointer1 : o_pointer0)
              == 16'($past(sel_ptr) - POINTER_STEP)))
    else $error("post-decrement address or pointer wrong");

  chk_relative_keeps: assert property ( // see RULE3
    s_take_rel |=> (o_mem_req.addr == 16'($past(sel_ptr)
                      + {{10{$past(i_instr[5])}}, $past(i_instr[5:0])}))
                   && $stable(o_pointer0) && $stable(o_pointer1))
    else $error("relative load moved the pointer or missed the address");

  chk_store_redirect: assert property ( // see RULE4
    s_take_store ##0 (file_addr == INDIRECT_DATA_PORT1_ADDR)
      |=> o_mem_req.wr && (o_mem_req.addr == $past(ptr_reg[1])))
    else $error("store to indirect port not redirected");

  chk_pointer_wrap: assert property ( // see RULE5
    s_take_ind ##0 (i_instr[1:0] == MODE_PRE_INC) ##0 (sel_ptr == 16'hFFFF)
      |=> (o_mem_req.addr == 16'h0000))
    else $error("pointer did not wrap to zero");

  chk_bank_load: assert property ( // see RULE6
    take && (opcode == OP_LOAD_BANK_LITERAL)
      |=> (o_bank_select_reg == $past(i_instr[4:0])) && !o_zero_update
          && $stable(o_zero_flag))
    else $error("bank load wrong or touched a flag");

  chk_page_load: assert property ( // see RULE7
    take && (opcode == OP_LOAD_PAGE_LITERAL)
      |=> (o_program_counter_high_latch == $past(i_instr[6:0])) && !o_zero_update)
    else $error("page load wrong or touched a flag");

  chk_literal_one_cycle: assert property ( // see RULE8
    take && (opcode == OP_LOAD_ACCUMULATOR_LITERAL)
      |=> (o_accumulator == $past(i_instr[7:0])) && o_ready && $stable(o_zero_flag))
    else $error("literal load not done in one cycle");

  chk_dont_care_bits: assert property ( // see RULE9
    take && (opcode == OP_LOAD_ACCUMULATOR_LITERAL)
      |=> !o_mem_req.rd && !o_mem_req.wr && $stable(o_bank_select_reg))
    else $error("literal load decoded as something else");

  chk_store_write: assert property ( // see RULE10
    s_take_store |=> (o_mem_req.wr && (o_mem_req.wdata == $past(acc_reg))
                      && !o_zero_update && o_ready)
                     ##1 (o_mem_req.wr
                          == $past(take && (opcode == OP_STORE_ACCUMULATOR_TO_FILE))))
    else $error("store did not write accumulator for exactly one cycle");

  chk_bank_address: assert property ( // see RULE11
    s_take_store ##0 (file_addr > INDIRECT_DATA_PORT1_ADDR)
      |=> (o_mem_req.addr == {4'h0, $past(bank_reg), $past(file_addr)}))
    else $error("direct address not formed from bank and file address");

endmodule

// file: move_exec_pkg.sv
// move_exec_pkg: shared constants, types and encodings of the move-instruction executor
// assumes a 14-bit instruction word and a byte-wide register file on the core clock

package move_exec_pkg;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_WIDTH = 14;
  localparam int unsigned OPCODE_MSB  = 13;
  localparam int unsigned OPCODE_LSB  = 10;

  localparam logic [3:0] OP_LOAD_ACCUMULATOR_LITERAL  = 4'h1;
  localparam logic [3:0] OP_STORE_ACCUMULATOR_TO_FILE = 4'h2;
  localparam logic [3:0] OP_LOAD_BANK_LITERAL         = 4'h3;
  localparam logic [3:0] OP_LOAD_PAGE_LITERAL         = 4'h4;
  localparam logic [3:0] OP_INDIRECT_LOAD_ACCUMULATOR = 4'h5;
  localparam logic [3:0] OP_INDIRECT_LOAD_RELATIVE    = 4'h6;

  // field positions
  localparam int unsigned IND_SELECT_BIT = 2;
  localparam int unsigned REL_SELECT_BIT = 6;

  // ----------------------------------------------------------------
  // pointer update modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ----------------------------------------------------------------
  // addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  INDIRECT_DATA_PORT0_ADDR = 7'h00;
  localparam logic [6:0]  INDIRECT_DATA_PORT1_ADDR = 7'h01;
  localparam logic [15:0] POINTER_RESET            = 16'h0000;
  localparam logic [7:0]  ACCUMULATOR_RESET        = 8'h00;
  localparam logic [4:0]  BANK_RESET               = 5'h00;
  localparam logic [6:0]  PAGE_RESET               = 7'h00;
  localparam logic [15:0] POINTER_STEP             = 16'h0001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } mem_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_READ = 2'h2
  } state_type;

endpackage

// file: pointer_step.sv
// pointer_step: effective address and next value of one file-select pointer
// assumes the caller registers both results; purely combinational

`timescale 1ns/1ps

module pointer_step
  import move_exec_pkg::*;
(
  input  wire logic [15:0] i_pointer,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_relative,
  input  wire logic [5:0]  i_offset,
  output logic      [15:0] o_eff_addr,
  output logic      [15:0] o_next_pointer
);

  logic [15:0] plus_one;
  logic [15:0] minus_one;
  logic [15:0] offset_ext;

  // 16-bit arithmetic wraps at both ends by itself
  assign plus_one   = 16'(i_pointer + POINTER_STEP);  // see RULE5
  assign minus_one  = 16'(i_pointer - POINTER_STEP);  // see RULE5
  assign offset_ext = {{10{i_offset[5]}}, i_offset};

  always_comb begin
    o_eff_addr     = i_pointer;
    o_next_pointer = i_pointer;
    if (i_relative) begin
      o_eff_addr = 16'(i_pointer + offset_ext);  // see RULE3
    end else begin
      case (i_mode)  // see RULE2
        MODE_PRE_INC: begin
          o_eff_addr     = plus_one;
          o_next_pointer = plus_one;
        end
        MODE_PRE_DEC: begin
          o_eff_addr     = minus_one;
          o_next_pointer = minus_one;
        end
        MODE_POST_INC: begin
          o_next_pointer = plus_one;
        end
        default: begin
          o_next_pointer = minus_one;
        end
      endcase
    end
  end

endmodule

// file: move_instruction_execution_test.sv
// move_instruction_execution_test: self-checking bench for the move-instruction executor
// assumes the register file is played by the bench, answering reads in the rd cycle

`timescale 1ns/1ps

module move_instruction_execution_test;
  import move_exec_pkg::*;

  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic              i_clk;
  logic              i_reset;
  logic              i_instr_valid;
  logic [13:0]       i_instr;
  logic [7:0]        i_mem_rdata;
  mem_req_type       o_mem_req;
  logic              o_ready;
  logic [7:0]        o_accumulator;
  logic [4:0]        o_bank_select_reg;
  logic [6:0]        o_program_counter_high_latch;
  logic              o_zero_flag;
  logic              o_zero_update;
  logic [15:0]       o_pointer0;
  logic [15:0]       o_pointer1;
  int                err_total;
  int                tests_run;
  logic [7:0]        exp_acc;

  `define CHK(name, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("MISMATCH %s expected %h seen %h", name, exp, got); \
    end \
  end

  move_instruction_execution dut (
    .i_instr                      (i_instr),
    .i_clk                        (i_clk),
    .i_reset                      (i_reset),
    .i_instr_valid                (i_instr_valid),
    .i_mem_rdata                  (i_mem_rdata),
    .o_mem_req                    (o_mem_req),
    .o_ready                      (o_ready),
    .o_accumulator                (o_accumulator),
    .o_bank_select_reg            (o_bank_select_reg),
    .o_program_counter_high_latch (o_program_counter_high_latch),
    .o_zero_flag                  (o_zero_flag),
    .o_zero_update                (o_zero_update),
    .o_pointer0                   (o_pointer0),
    .o_pointer1                   (o_pointer1)
  );

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // valid stays up so back-to-back words need no gap; idle drops it
  task automatic issue(input logic [13:0] w);
    i_instr = w;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
  endtask

  task automatic idle();
    i_instr_valid = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic do_ind(input logic [13:0] w, input logic [7:0] d,
                        input logic [15:0] eaddr, input logic [15:0] eptr);
    logic sel;
    sel = (w[13:10] == 4'h6) ? w[6] : w[2];
    i_instr = w;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
    i_instr_valid = 1'b0;
    i_mem_rdata = d;
    `CHK("rd", 1'b1, o_mem_req.rd)
    `CHK("ready", 1'b0, o_ready)
    `CHK("addr", eaddr, o_mem_req.addr)
    `CHK("ptr", eptr, sel ? o_pointer1 : o_pointer0)
    @(negedge i_clk);
    // released bus shows inverse so a late sample cannot pass by luck
    i_mem_rdata = ~d;
    exp_acc = d;
    `CHK("acc", d, o_accumulator)
    `CHK("zflag", (d == 8'h00), o_zero_flag)
    `CHK("zupd", 1'b1, o_zero_update)
    `CHK("rd_end", 1'b0, o_mem_req.rd)
    `CHK("ready_back", 1'b1, o_ready)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_literal();
    // upper don't-care bits set on purpose
    issue({4'h1, 2'b11, 8'h5A});
    exp_acc = 8'h5A;
    `CHK("lit_acc", 8'h5A, o_accumulator)
    `CHK("lit_zupd", 1'b0, o_zero_update)
    issue({4'h3, 5'h00, 5'h1F});
    `CHK("bank", 5'h1F, o_bank_select_reg)
    `CHK("bank_zupd", 1'b0, o_zero_update)
    issue({4'h4, 3'h0, 7'h7F});
    `CHK("page", 7'h7F, o_program_counter_high_latch)
    `CHK("page_zupd", 1'b0, o_zero_update)
    `CHK("bank_keep", 5'h1F, o_bank_select_reg)
    idle();
    $display("test literal loads done");
  endtask

  task automatic t_store();
    issue({4'h2, 3'h0, 7'h7F});
    i_instr_valid = 1'b0;
    `CHK("st_wr", 1'b1, o_mem_req.wr)
    `CHK("st_addr", {4'h0, 5'h1F, 7'h7F}, o_mem_req.addr)
    `CHK("st_wdata", exp_acc, o_mem_req.wdata)
    `CHK("st_zupd", 1'b0, o_zero_update)
    @(negedge i_clk);
    `CHK("st_wr_end", 1'b0, o_mem_req.wr)
    // unknown opcode is taken and must leave everything alone
    issue({4'h0, 10'h3FF});
    `CHK("unk_wr", 1'b0, o_mem_req.wr)
    `CHK("unk_acc", exp_acc, o_accumulator)
    $display("test store done");
  endtask

  task automatic t_modes();
    do_ind({4'h5, 7'h00, 1'b0, 2'b01}, 8'h00, 16'hFFFF, 16'hFFFF);
    do_ind({4'h5, 7'h00, 1'b0, 2'b00}, 8'h80, 16'h0000, 16'h0000);
    do_ind({4'h5, 7'h00, 1'b0, 2'b11}, 8'h00, 16'h0000, 16'hFFFF);
    do_ind({4'h5, 7'h00, 1'b0, 2'b10}, 8'h3C, 16'hFFFF, 16'h0000);
    `CHK("ind_bank", 5'h1F, o_bank_select_reg)
    `CHK("ind_page", 7'h7F, o_program_counter_high_latch)
    $display("test pointer modes done");
  endtask

  task automatic t_relative();
    do_ind({4'h6, 3'h0, 1'b1, 6'h20}, 8'h11, 16'hFFE0, 16'h0000);
    do_ind({4'h6, 3'h0, 1'b1, 6'h1F}, 8'h00, 16'h001F, 16'h0000);
    do_ind({4'h5, 7'h00, 1'b1, 2'b01}, 8'h9E, 16'hFFFF, 16'hFFFF);
    `CHK("rel_p0", 16'h0000, o_pointer0)
    // store through the indirect port of pointer1
    issue({4'h2, 3'h0, 7'h01});
    i_instr_valid = 1'b0;
    `CHK("ind_st_addr", 16'hFFFF, o_mem_req.addr)
    `CHK("ind_st_wdata", 8'h9E, o_mem_req.wdata)
    `CHK("ind_st_wr", 1'b1, o_mem_req.wr)
    @(negedge i_clk);
    $display("test relative and indirect port done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // whole run is well under 100 cycles; 2500 gives ample margin
  initial begin
    #20000;
    err_total++;
    test_done();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    exp_acc = 8'h00;
    i_reset = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_mem_rdata = 8'h00;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("rst_ready", 1'b0, o_ready)
    `CHK("rst_p0", 16'h0000, o_pointer0)
    i_reset = 1'b0;
    @(negedge i_clk);
    `CHK("ready_up", 1'b1, o_ready)
    t_literal();
    t_store();
    t_modes();
    t_relative();
    test_done();
  end

endmodule
